// ---- mmpt_mmss_counter.sv ----
// Minutes:seconds counter with load, clear, count down and count up
`timescale 1ns/1ps
module mmpt_mmss_counter
    import mmpt_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    mmpt_mmss_if.cnt tc
);

    logic [MIN_W-1:0] min_r;
    logic [SEC_W-1:0] sec_r;
    logic is_zero;
    logic is_max;

    assign is_zero = (min_r == MIN_RST) && (sec_r == SEC_RST);
    assign is_max = (min_r == MIN_MAX) && (sec_r == SEC_MAX);
    assign tc.min = min_r;
    assign tc.sec = sec_r;

    // Load beats clear beats count; down stops at 00:00, up at 999:59
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            min_r <= MIN_RST;
            sec_r <= SEC_RST;
        end else if (tc.load) begin
            min_r <= mmpt_clamp_min(tc.load_min);
            sec_r <= mmpt_clamp_sec(tc.load_sec);
        end else if (tc.clr) begin
            min_r <= MIN_RST;
            sec_r <= SEC_RST;
        end else if (tc.dec && !is_zero) begin
            if (sec_r == SEC_RST) begin
                sec_r <= SEC_MAX;
                min_r <= min_r - 10'h001;
            end else begin
                sec_r <= sec_r - 6'h01;
            end
        end else if (tc.inc && !is_max) begin
            if (sec_r == SEC_MAX) begin
                sec_r <= SEC_RST;
                min_r <= min_r + 10'h001;
            end else begin
                sec_r <= sec_r + 6'h01;
            end
        end
    end

endmodule // mmpt_mmss_counter

// ---- mmpt_mmss_if.sv ----
// Control and value bundle of one minutes:seconds counter
`timescale 1ns/1ps
interface mmpt_mmss_if;
    import mmpt_pkg::*;
    logic [MIN_W-1:0] min;
    logic [SEC_W-1:0] sec;
    logic load;
    logic [MIN_W-1:0] load_min;
    logic [SEC_W-1:0] load_sec;
    logic clr;
    logic inc;
    logic dec;

    modport ctrl (
        output load,
        output load_min,
        output load_sec,
        output clr,
        output inc,
        output dec,
        input min,
        input sec
    );

    modport cnt (
        input load,
        input load_min,
        input load_sec,
        input clr,
        input inc,
        input dec,
        output min,
        output sec
    );
endinterface

// ---- mmpt_pkg.sv ----
// Shared constants and types for the multi mode process timer
package mmpt_pkg;

    localparam int MIN_W = 10;
    localparam int SEC_W = 6;

    localparam logic [MIN_W-1:0] MIN_MAX = 10'h3E7;
    localparam logic [SEC_W-1:0] SEC_MAX = 6'h3B;
    localparam logic [MIN_W-1:0] MIN_RST = 10'h000;
    localparam logic [SEC_W-1:0] SEC_RST = 6'h00;

    localparam int MODE_W = 3;
    localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
    localparam logic [MODE_W-1:0] MODE_EDGE_PULSE = 3'h1;
    localparam logic [MODE_W-1:0] MODE_ON_DELAY = 3'h2;
    localparam logic [MODE_W-1:0] MODE_ONE_SHOT = 3'h3;
    localparam logic [MODE_W-1:0] MODE_HOLD_ON = 3'h4;
    localparam logic [MODE_W-1:0] MODE_RST = MODE_OFF;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TIMING,
        ST_ACTIVE
    } mmpt_state_e;

    function automatic logic [MIN_W-1:0] mmpt_clamp_min(input logic [MIN_W-1:0] m);
        mmpt_clamp_min = (m > MIN_MAX) ? MIN_MAX : m;
    endfunction

    function automatic logic [SEC_W-1:0] mmpt_clamp_sec(input logic [SEC_W-1:0] s);
        mmpt_clamp_sec = (s > SEC_MAX) ? SEC_MAX : s;
    endfunction

endpackage

// ---- mmpt_tb.sv ----
// Self-checking testbench for the multi mode process timer
`timescale 1ns/1ps
module testbench
    import mmpt_pkg::*;
;
    logic clock, reset_n, wr_duration, tick_1s, want, trigger_in, timer_out, triggered_flag;
    logic [MODE_W-1:0] timer_type;
    logic [MIN_W-1:0] wr_min, set_min, remain_min, elapsed_min;
    logic [SEC_W-1:0] wr_sec, set_sec, remain_sec, elapsed_sec;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    wire [15:0] rem = {remain_min, remain_sec};
    wire [15:0] ela = {elapsed_min, elapsed_sec};
    wire [15:0] set = {set_min, set_sec};
    wire [1:0] of = {timer_out, triggered_flag};

    mmpt_timer dut (
        .clock(clock),
        .reset_n(reset_n),
        .timer_type(timer_type),
        .wr_min(wr_min),
        .wr_sec(wr_sec),
        .wr_duration(wr_duration),
        .tick_1s(tick_1s),
        .trigger_in(trigger_in),
        .timer_out(timer_out),
        .triggered_flag(triggered_flag),
        .set_min(set_min),
        .set_sec(set_sec),
        .remain_min(remain_min),
        .remain_sec(remain_sec),
        .elapsed_min(elapsed_min),
        .elapsed_sec(elapsed_sec)
    );
    mmpt_trig_src src (.clock(clock), .want(want), .trig(trigger_in));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            tick_1s = 1'b1;
            cyc(1);
            tick_1s = 1'b0;
            cyc(1);
        end
    endtask
    task automatic wr(input logic [MIN_W-1:0] m, input logic [SEC_W-1:0] s);
        wr_min = m;
        wr_sec = s;
        wr_duration = 1'b1;
        cyc(1);
        wr_duration = 1'b0;
        cyc(1);
    endtask
    task automatic trig(input logic v);
        want = v;
        cyc(2);
    endtask
    task automatic mode(input logic [MODE_W-1:0] t);
        timer_type = t;
        cyc(2);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        reset_n = 1'b0;
        timer_type = MODE_OFF;
        wr_min = 10'h000;
        wr_sec = 6'h00;
        wr_duration = 1'b0;
        tick_1s = 1'b0;
        want = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        reset_n = 1'b1;
        cyc(1);
        chk(of, 2'b00);
        chk(set, 16'h0000);
        chk(ela, 16'h0000);
        mode(MODE_EDGE_PULSE);
        wr(10'h3FF, 6'h3F);
        chk(set, 16'hF9FB);
        wr(10'h001, 6'h00);
        trig(1'b1);
        chk(of, 2'b11);
        chk(rem, 16'h0040);
        tick(1);
        chk(rem, 16'h003B);
        chk(ela, 16'h0001);
        wr(10'h000, 6'h02);
        trig(1'b0);
        trig(1'b1);
        chk(rem, 16'h0002);
        tick(1);
        chk(of, 2'b11);
        tick(1);
        cyc(1);
        chk(of, 2'b00);
        trig(1'b0);
        mode(MODE_ON_DELAY);
        wr(10'h000, 6'h02);
        trig(1'b1);
        chk(of, 2'b01);
        tick(1);
        trig(1'b0);
        chk(of, 2'b00);
        trig(1'b1);
        tick(1);
        chk(of, 2'b01);
        tick(1);
        chk(of, 2'b11);
        trig(1'b0);
        chk(of, 2'b00);
        mode(MODE_ONE_SHOT);
        trig(1'b1);
        wr(10'h000, 6'h02);
        chk(rem, 16'h0002);
        chk(of, 2'b11);
        trig(1'b0);
        tick(1);
        chk(rem, 16'h0002);
        chk(of, 2'b01);
        trig(1'b1);
        tick(1);
        chk(rem, 16'h0001);
        wr(10'h000, 6'h03);
        chk(rem, 16'h0003);
        tick(3);
        chk(of, 2'b00);
        tick(1);
        chk(rem, 16'h0000);
        trig(1'b0);
        mode(MODE_HOLD_ON);
        wr(10'h000, 6'h02);
        trig(1'b1);
        chk(of, 2'b10);
        trig(1'b0);
        tick(1);
        chk(ela, 16'h0001);
        chk(of, 2'b11);
        trig(1'b1);
        chk(ela, 16'h0000);
        trig(1'b0);
        tick(2);
        cyc(1);
        chk(ela, 16'h0002);
        chk(of, 2'b01);
        mode(MODE_OFF);
        trig(1'b1);
        tick(1);
        chk(of, 2'b00);
        stop_test();
    end
endmodule // testbench

// ---- mmpt_timer.sv ----
// Multi mode process timer: pulse, on delay, one shot and minimum on
`timescale 1ns/1ps
module mmpt_timer
    import mmpt_pkg::*;
#(
    parameter int MINUTE_WIDTH = MIN_W,
    parameter int SECOND_WIDTH = SEC_W
)(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [MODE_W-1:0] timer_type,
    input wire logic [MIN_W-1:0] wr_min,
    input wire logic [SEC_W-1:0] wr_sec,
    input wire logic wr_duration,
    input wire logic tick_1s,
    input wire logic trigger_in,
    output logic timer_out,
    output logic triggered_flag,
    output logic [MIN_W-1:0] set_min,
    output logic [SEC_W-1:0] set_sec,
    output logic [MIN_W-1:0] remain_min,
    output logic [SEC_W-1:0] remain_sec,
    output logic [MIN_W-1:0] elapsed_min,
    output logic [SEC_W-1:0] elapsed_sec
);

    // Ports and counters are sized by the package widths
    if (MINUTE_WIDTH != MIN_W) begin : g_bad_minute_width
        $error("mmpt_timer: MINUTE_WIDTH must stay at 10 bits");
    end
    if (SECOND_WIDTH != SEC_W) begin : g_bad_second_width
        $error("mmpt_timer: SECOND_WIDTH must stay at 6 bits");
    end

    // Remaining time, loaded from the set duration or a one shot write
    mmpt_mmss_if rem_if();
    // Elapsed time, counted up while timing
    mmpt_mmss_if ela_if();

    mmpt_mmss_counter u_remain (
        .clock(clock),
        .reset_n(reset_n),
        .tc(rem_if.cnt)
    );

    mmpt_mmss_counter u_elapsed (
        .clock(clock),
        .reset_n(reset_n),
        .tc(ela_if.cnt)
    );

    // Registered state and outputs, with their combinational next values
    mmpt_state_e state_r;
    mmpt_state_e state_nxt;
    logic [MODE_W-1:0] mode_r;
    logic trig_d_r;
    logic out_r;
    logic out_nxt;
    logic flag_r;
    logic flag_nxt;
    logic [MIN_W-1:0] set_min_r;
    logic [SEC_W-1:0] set_sec_r;

    // Decoded conditions
    logic rise;
    logic fall;
    logic rem_zero;
    logic ela_zero;
    logic ela_done;
    // Write data clamped to 999:59
    logic [MIN_W-1:0] wr_min_c;
    logic [SEC_W-1:0] wr_sec_c;
    logic wr_nonzero;
    logic mode_chg;
    logic [MIN_W+SEC_W-1:0] rem_mmss;
    logic [MIN_W+SEC_W-1:0] ela_mmss;
    logic [MIN_W+SEC_W-1:0] set_mmss;

    // Edges against the registered input
    assign rise = trigger_in && !trig_d_r;
    assign fall = !trigger_in && trig_d_r;
    // A new mode code restarts the timer
    assign mode_chg = (timer_type != mode_r);
    // Packed minutes:seconds views; seconds never pass 59, so order is kept
    assign rem_mmss = {rem_if.min, rem_if.sec};
    assign ela_mmss = {ela_if.min, ela_if.sec};
    assign set_mmss = {set_min_r, set_sec_r};
    assign rem_zero = (rem_mmss == {MIN_RST, SEC_RST});
    assign ela_zero = (ela_mmss == {MIN_RST, SEC_RST});
    // Reached, not only equal: a shorter set duration still ends the hold
    assign ela_done = (ela_mmss >= set_mmss);
    assign wr_min_c = mmpt_clamp_min(wr_min);
    assign wr_sec_c = mmpt_clamp_sec(wr_sec);
    assign wr_nonzero = (wr_min_c != MIN_RST) || (wr_sec_c != SEC_RST);

    // Input history for edge detection
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trigger_in;
        end
    end

    // Last seen mode; a change restarts the timer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= MODE_RST;
        end else begin
            mode_r <= timer_type;
        end
    end

    // Set duration, written at any moment
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            set_min_r <= MIN_RST;
            set_sec_r <= SEC_RST;
        end else if (wr_duration) begin
            set_min_r <= wr_min_c;
            set_sec_r <= wr_sec_c;
        end
    end

    // Next state, outputs and counter commands per mode
    always_comb begin
        state_nxt = state_r;
        out_nxt = out_r;
        flag_nxt = flag_r;
        rem_if.load = 1'b0;
        rem_if.load_min = set_min_r;
        rem_if.load_sec = set_sec_r;
        rem_if.clr = 1'b0;
        rem_if.dec = 1'b0;
        rem_if.inc = 1'b0;
        ela_if.load = 1'b0;
        ela_if.load_min = MIN_RST;
        ela_if.load_sec = SEC_RST;
        ela_if.clr = 1'b0;
        ela_if.dec = 1'b0;
        ela_if.inc = 1'b0;
        // One cycle of clearing on every mode change
        if (mode_chg) begin
            state_nxt = ST_IDLE;
            out_nxt = 1'b0;
            flag_nxt = 1'b0;
            rem_if.clr = 1'b1;
            ela_if.clr = 1'b1;
        end else begin
            case (timer_type)
                // Pulse: every rise restarts the period
                MODE_EDGE_PULSE: begin
                    if (rise) begin
                        rem_if.load = 1'b1;
                        ela_if.clr = 1'b1;
                        state_nxt = ST_TIMING;
                        out_nxt = 1'b1;
                        flag_nxt = 1'b1;
                    end else if (state_r == ST_TIMING) begin
                        if (rem_zero) begin
                            state_nxt = ST_IDLE;
                            out_nxt = 1'b0;
                            flag_nxt = 1'b0;
                        end else if (tick_1s) begin
                            rem_if.dec = 1'b1;
                            ela_if.inc = 1'b1;
                        end
                    end
                end
                // On delay: a low input abandons the wait
                MODE_ON_DELAY: begin
                    if (!trigger_in) begin
                        state_nxt = ST_IDLE;
                        out_nxt = 1'b0;
                        flag_nxt = 1'b0;
                    end else if (rise) begin
                        rem_if.load = 1'b1;
                        ela_if.clr = 1'b1;
                        state_nxt = ST_TIMING;
                        out_nxt = 1'b0;
                        flag_nxt = 1'b1;
                    end else if (state_r == ST_TIMING) begin
                        if (rem_zero) begin
                            state_nxt = ST_ACTIVE;
                            out_nxt = 1'b1;
                        end else if (tick_1s) begin
                            rem_if.dec = 1'b1;
                            ela_if.inc = 1'b1;
                        end
                    end
                end
                // One shot: a write beats a tick in the same cycle
                MODE_ONE_SHOT: begin
                    if (wr_duration) begin
                        rem_if.load = 1'b1;
                        rem_if.load_min = wr_min_c;
                        rem_if.load_sec = wr_sec_c;
                        ela_if.clr = 1'b1;
                        state_nxt = wr_nonzero ? ST_TIMING : ST_IDLE;
                        flag_nxt = wr_nonzero;
                    end else if (state_r == ST_TIMING) begin
                        if (rem_zero) begin
                            state_nxt = ST_IDLE;
                            flag_nxt = 1'b0;
                        end else if (trigger_in && tick_1s) begin
                            rem_if.dec = 1'b1;
                            ela_if.inc = 1'b1;
                        end
                    end
                    // Gate acts on the output at once, on the count only at ticks
                    out_nxt = (state_nxt == ST_TIMING) && trigger_in;
                end
                // Minimum on: counting starts only once the input falls
                MODE_HOLD_ON: begin
                    if (rise) begin
                        out_nxt = 1'b1;
                        ela_if.clr = 1'b1;
                        state_nxt = ST_ACTIVE;
                    end else if (fall && out_r) begin
                        state_nxt = ST_TIMING;
                    end else if (state_r == ST_TIMING) begin
                        if (ela_done) begin
                            out_nxt = 1'b0;
                            state_nxt = ST_IDLE;
                        end else if (tick_1s) begin
                            ela_if.inc = 1'b1;
                        end
                    end
                    // Flag follows the elapsed value one cycle late
                    flag_nxt = !ela_zero;
                end
                // Off and unused codes ignore the input
                default: begin
                    state_nxt = ST_IDLE;
                    out_nxt = 1'b0;
                    flag_nxt = 1'b0;
                end
            endcase
        end
    end

    // Mode state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Timer output
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // Triggered flag
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Outputs straight from registers
    assign timer_out = out_r;
    assign triggered_flag = flag_r;
    assign set_min = set_min_r;
    assign set_sec = set_sec_r;
    assign remain_min = rem_if.min;
    assign remain_sec = rem_if.sec;
    assign elapsed_min = ela_if.min;
    assign elapsed_sec = ela_if.sec;

endmodule // mmpt_timer

// ---- mmpt_timer_props.sv ----
// Port level assertion checker for the multi mode process timer
`timescale 1ns/1ps
module mmpt_timer_props
    import mmpt_pkg::*;
#(
    parameter int MINUTE_WIDTH = MIN_W,
    parameter int SECOND_WIDTH = SEC_W
)(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [MODE_W-1:0] timer_type,
    input wire logic [MIN_W-1:0] wr_min,
    input wire logic [SEC_W-1:0] wr_sec,
    input wire logic wr_duration,
    input wire logic tick_1s,
    input wire logic trigger_in,
    input wire logic timer_out,
    input wire logic triggered_flag,
    input wire logic [MIN_W-1:0] set_min,
    input wire logic [SEC_W-1:0] set_sec,
    input wire logic [MIN_W-1:0] remain_min,
    input wire logic [SEC_W-1:0] remain_sec,
    input wire logic [MIN_W-1:0] elapsed_min,
    input wire logic [SEC_W-1:0] elapsed_sec
);
    logic [MODE_W-1:0] prev_r;
    logic seen_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= MODE_OFF;
            seen_r <= 1'b0;
        end else begin
            prev_r <= timer_type;
            seen_r <= 1'b1;
        end
    end
    // Mode held since the previous edge
    wire same = seen_r && (prev_r == timer_type);
    wire m1 = same && (timer_type == MODE_EDGE_PULSE);
    wire m2 = same && (timer_type == MODE_ON_DELAY);
    wire m3 = same && (timer_type == MODE_ONE_SHOT);
    wire m4 = same && (timer_type == MODE_HOLD_ON);
    wire rem0 = (remain_min == MIN_RST) && (remain_sec == SEC_RST);
    wire ela0 = (elapsed_min == MIN_RST) && (elapsed_sec == SEC_RST);
    wire at_set = (elapsed_min == set_min) && (elapsed_sec == set_sec);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_off; timer_type == MODE_OFF |=> !timer_out && !triggered_flag; endproperty
    property p_change; seen_r && !same |=> !timer_out && !triggered_flag && rem0 && ela0; endproperty
    property p_pulse_rise; m1 && $past(same) && trigger_in && !$past(trigger_in) |=> timer_out && triggered_flag;
    endproperty
    property p_pulse_end; m1 && timer_out && rem0 && !(trigger_in && !$past(trigger_in)) |=> !timer_out;
    endproperty
    property p_delay_off; m2 && !trigger_in |=> !timer_out; endproperty
    property p_delay_wait; m2 && !timer_out && !rem0 |=> !timer_out; endproperty
    property p_shot_gate; m3 && !trigger_in |=> !timer_out; endproperty
    property p_shot_hold; m3 && !trigger_in && !wr_duration |=> $stable(remain_min) && $stable(remain_sec);
    endproperty
    property p_shot_wr; m3 && wr_duration && wr_min <= MIN_MAX && wr_sec <= SEC_MAX && (wr_min != MIN_RST ||
        wr_sec != SEC_RST) |=> remain_min == $past(wr_min) && remain_sec == $past(wr_sec) && triggered_flag;
    endproperty
    property p_hold_rise; m4 && $past(same) && trigger_in && !$past(trigger_in) |=> timer_out && ela0; endproperty
    property p_hold_flag; m4 && $past(same) |-> triggered_flag == !$past(ela0); endproperty
    property p_hold_end; m4 && timer_out && !trigger_in && at_set && !ela0 |=> !timer_out; endproperty

    a_off: assert property (p_off) else $error("output active in off mode");
    a_change: assert property (p_change) else $error("mode change did not clear");
    a_pulse_rise: assert property (p_pulse_rise) else $error("pulse did not start");
    a_pulse_end: assert property (p_pulse_end) else $error("pulse outlived period");
    a_delay_off: assert property (p_delay_off) else $error("delay output without trigger");
    a_delay_wait: assert property (p_delay_wait) else $error("delay output too early");
    a_shot_gate: assert property (p_shot_gate) else $error("one shot output ungated");
    a_shot_hold: assert property (p_shot_hold) else $error("one shot time moved while gated");
    a_shot_wr: assert property (p_shot_wr) else $error("one shot write not taken");
    a_hold_rise: assert property (p_hold_rise) else $error("hold rise not seen");
    a_hold_flag: assert property (p_hold_flag) else $error("hold flag wrong");
    a_hold_end: assert property (p_hold_end) else $error("hold did not end");

    c_pulse: cover property (m1 && $rose(timer_out));
    c_shot_wr: cover property (m3 && wr_duration);
    c_hold_end: cover property (m4 && $fell(timer_out));
endmodule // mmpt_timer_props

bind mmpt_timer mmpt_timer_props #(.MINUTE_WIDTH(MINUTE_WIDTH), .SECOND_WIDTH(SECOND_WIDTH)) u_props (.*);

// ---- mmpt_trig_src.sv ----
// Registered trigger source feeding the timer input
`timescale 1ns/1ps
module mmpt_trig_src (
    input wire logic clock,
    input wire logic want,
    output logic trig
);
    initial trig = 1'b0;
    always @(posedge clock) begin
        trig <= #1 want;
    end
endmodule // mmpt_trig_src
